// [rtl/fqc_host.sv]
`timescale 1ns/10ps
`default_nettype none
// Operation
// - sector erase: two unlocks, 80 setup, two unlocks, 30 at sector; more 30 add sectors
// - bank erase: same five writes, then 10 at bank address
// - pause erase with one B0 write, then read until toggling stops
// - continue paused erase with one 30 write inside the bank
// - double-word program addresses differ only in bit zero
// - F0 write selects array read until next write cycle
module fqc_host #(
   parameter int ADDR_W = 21
) (
   input  wire logic              clk,
   input  wire logic              reset_n,
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [7:0]        wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output var  logic [31:0]       wb_dat_o,
   output var  logic              wb_ack_o,
   output var  logic [ADDR_W-1:0] flash_addr,
   input  wire logic [15:0]       flash_dq_in,
   output var  logic [15:0]       flash_dq_out,
   output var  logic              flash_dq_oe,
   output var  logic              flash_ce_n,
   output var  logic              flash_we_n,
   output var  logic              flash_oe_n
);
   import fqc_pkg::*;

   fqc_state_e  state, next_state;
   fqc_op_e     op, next_op;
   logic [3:0]  cnt, next_cnt;
   logic [2:0]  step, next_step;
   logic [31:0] addr_word, wdata_word;
   logic [15:0] rdata;
   logic [15:0] dq_s1, dq_s2;
   logic        refused;
   logic        poll_have, poll_prev, poll_stop;

   ////////////////////////////////////////////////////////////////////////////
   // command steps
   function automatic logic [13:0] step_f(input fqc_op_e o, input logic [2:0] i);
      logic [13:0] s, u1, u2;
      u1 = {1'b0, AS_555, DS_CODE, CMD_UNLOCK1};
      u2 = {1'b0, AS_2AA, DS_CODE, CMD_UNLOCK2};
      s  = {1'b1, AS_555, DS_CODE, CMD_READ_ARR};
      case (o)
         OP_LOCK: begin
            case (i)
               3'h0: s = u1;
               3'h1: s = u2;
               3'h2: s = {1'b0, AS_555, DS_CODE, CMD_LOCK_SET};
               default: s = {1'b1, AS_USR, DS_CODE, CMD_LOCK_CNF};
            endcase
         end
         OP_SERASE, OP_BERASE: begin
            case (i)
               3'h0: s = u1;
               3'h1: s = u2;
               3'h2: s = {1'b0, AS_555, DS_CODE, CMD_ERASE_SET};
               3'h3: s = u1;
               3'h4: s = u2;
               default: s = {1'b1, AS_USR, DS_CODE, (o == OP_SERASE) ? CMD_SECT_ERASE : CMD_BANK_ERASE};
            endcase
         end
         OP_SADD: s = {1'b1, AS_USR, DS_CODE, CMD_SECT_ERASE};
         OP_PAUSE: s = {1'b1, AS_USR, DS_CODE, CMD_PAUSE};
         OP_CONT: s = {1'b1, AS_USR, DS_CODE, CMD_CONTINUE};
         OP_QUERY: s = {1'b1, AS_Q55, DS_CODE, CMD_QUERY};
         OP_IDSEL: begin
            case (i)
               3'h0: s = u1;
               3'h1: s = u2;
               default: s = {1'b1, AS_555, DS_CODE, CMD_ID_SEL};
            endcase
         end
         // pair of words on even then odd address
         OP_DWPROG: begin
            case (i)
               3'h0: s = u1;
               3'h1: s = u2;
               3'h2: s = {1'b0, AS_555, DS_CODE, CMD_DWPROG};
               3'h3: s = {1'b0, AS_EVN, DS_LO, 8'h00};
               default: s = {1'b1, AS_ODD, DS_HI, 8'h00};
            endcase
         end
         // reset and any unknown opcode write F0
         default: s = {1'b1, AS_555, DS_CODE, CMD_READ_ARR};
      endcase
      return s;
   endfunction : step_f
   function automatic logic [31:0] lane_f(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction : lane_f

   ////////////////////////////////////////////////////////////////////////////
   // bus decode
   wire              wb_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire              wb_wr      = wb_req & wb_we_i;
   wire              hit_ctrl   = wb_adr_i == REG_CTRL;
   wire              hit_addr   = wb_adr_i == REG_ADDR;
   wire              hit_wdata  = wb_adr_i == REG_WDATA;
   wire              hit_stat   = wb_adr_i == REG_STAT;
   wire              hit_rdata  = wb_adr_i == REG_RDATA;
   wire              busy       = state != S_IDLE;
   wire              ctrl_wr    = wb_wr & hit_ctrl & wb_sel_i[0];
   wire              start      = ctrl_wr & ~busy;
   wire              refuse_set = ctrl_wr & busy;
   wire              refuse_clr = wb_wr & hit_stat & wb_sel_i[0] & wb_dat_i[STAT_REFUSED];
   wire fqc_op_e     new_op     = fqc_op_e'(wb_dat_i[3:0]);
   wire [ADDR_W-1:0] usr_addr   = addr_word[ADDR_W-1:0];
   wire [31:0]       stat_word  = {29'h0, poll_stop, refused, busy};
   wire [31:0]       rd_mux     = hit_ctrl  ? {28'h0, op} :
                                  hit_addr  ? {{(32-ADDR_W){1'b0}}, usr_addr} :
                                  hit_wdata ? wdata_word :
                                  hit_stat  ? stat_word :
                                  hit_rdata ? {16'h0, rdata} : 32'h0;

   ////////////////////////////////////////////////////////////////////////////
   // next step address and data
   wire [13:0]       nstep      = step_f(next_op, next_step);
   wire [13:0]       cur_step   = step_f(op, step);
   wire              step_last  = cur_step[13];
   wire [2:0]        n_asel     = nstep[12:10];
   wire [1:0]        n_dsel     = nstep[9:8];
   // coded cycles drive the upper address bits low
   wire [ADDR_W-1:0] n_addr     = (n_asel == AS_555) ? ADDR_W'(UNLOCK_A1) :
                                  (n_asel == AS_2AA) ? ADDR_W'(UNLOCK_A2) :
                                  (n_asel == AS_Q55) ? ADDR_W'(QUERY_ADDR) :
                                  (n_asel == AS_EVN) ? {usr_addr[ADDR_W-1:1], 1'b0} :
                                  (n_asel == AS_ODD) ? {usr_addr[ADDR_W-1:1], 1'b1} : usr_addr;
   wire [15:0]       n_data     = (n_dsel == DS_LO) ? wdata_word[15:0] :
                                  (n_dsel == DS_HI) ? wdata_word[31:16] : {8'h00, nstep[7:0]};
   wire              stop_seen  = poll_have & (poll_prev == dq_s2[POLL_BIT]);
   wire              in_write   = (next_state == S_WSET) | (next_state == S_WPUL) | (next_state == S_WREC);

   ////////////////////////////////////////////////////////////////////////////
   // sequencer
   always_comb begin
      next_state = state;
      next_cnt   = cnt;
      next_step  = step;
      next_op    = start ? new_op : op;
      case (state)
         S_IDLE: begin
            if (start) begin
               next_step = 3'h0;
               // plain read at the applied offset, repeatable
               if (new_op == OP_READ) begin
                  next_state = S_READ;
                  next_cnt   = READ_CYC - 4'h1;
               end else begin
                  next_state = S_WSET;
               end
            end
         end
         S_WSET: begin
            next_state = S_WPUL;
            next_cnt   = WP_CYC - 4'h1;
         end
         S_WPUL: begin
            next_cnt = cnt - 4'h1;
            if (cnt == 4'h0) begin
               next_state = S_WREC;
               next_cnt   = WPH_CYC - 4'h1;
            end
         end
         S_WREC: begin
            next_cnt = cnt - 4'h1;
            if (cnt == 4'h0) begin
               if (!step_last) begin
                  next_state = S_WSET;
                  next_step  = step + 3'h1;
               end else if (op == OP_PAUSE) begin
                  // poll until the toggle bit settles
                  next_state = S_READ;
                  next_cnt   = READ_CYC - 4'h1;
               end else begin
                  next_state = S_IDLE;
               end
            end
         end
         S_READ: begin
            next_cnt = cnt - 4'h1;
            if (cnt == 4'h0) begin
               next_state = S_GAP;
            end
         end
         S_GAP: begin
            next_state = S_IDLE;
            if (op == OP_PAUSE && !poll_stop) begin
               next_state = S_READ;
               next_cnt   = READ_CYC - 4'h1;
            end
         end
         default: next_state = S_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= S_IDLE;
         op    <= OP_READ;
         cnt   <= 4'h0;
         step  <= 3'h0;
      end else begin
         state <= next_state;
         op    <= next_op;
         cnt   <= next_cnt;
         step  <= next_step;
      end
   end

   // pin data passes two flops before use
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         dq_s1 <= 16'h0;
         dq_s2 <= 16'h0;
      end else begin
         dq_s1 <= flash_dq_in;
         dq_s2 <= dq_s1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata     <= 16'h0;
         poll_have <= 1'b0;
         poll_prev <= 1'b0;
         poll_stop <= 1'b0;
      end else if (start) begin
         poll_have <= 1'b0;
         poll_stop <= 1'b0;
      end else if (state == S_READ && cnt == 4'h0) begin
         rdata     <= dq_s2;
         poll_have <= 1'b1;
         poll_prev <= dq_s2[POLL_BIT];
         poll_stop <= stop_seen;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pins, all from flops; a read never overlaps a driven bus
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         flash_ce_n   <= 1'b1;
         flash_we_n   <= 1'b1;
         flash_oe_n   <= 1'b1;
         flash_dq_oe  <= 1'b0;
         flash_addr   <= '0;
         flash_dq_out <= 16'h0;
      end else begin
         flash_ce_n  <= (next_state == S_IDLE) | (next_state == S_GAP);
         flash_we_n  <= next_state != S_WPUL;
         flash_oe_n  <= next_state != S_READ;
         flash_dq_oe <= in_write;
         if (next_state == S_WSET) begin
            flash_addr   <= n_addr;
            flash_dq_out <= n_data;
         end else if (next_state == S_READ) begin
            flash_addr <= usr_addr;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register slave, answers every access one cycle after the strobe
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wb_ack_o   <= 1'b0;
         wb_dat_o   <= 32'h0;
         addr_word  <= 32'h0;
         wdata_word <= 32'h0;
         refused    <= 1'b0;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_req && !wb_we_i) begin
            wb_dat_o <= rd_mux;
         end
         // address and data may be changed mid-command; they are sampled per step
         if (wb_wr && hit_addr) begin
            addr_word <= lane_f(addr_word, wb_dat_i, wb_sel_i);
         end
         if (wb_wr && hit_wdata) begin
            wdata_word <= lane_f(wdata_word, wb_dat_i, wb_sel_i);
         end
         // set wins over clear
         refused <= refuse_set | (refused & ~refuse_clr);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence pause_done_s;
      state == S_WREC && op == OP_PAUSE && cnt == 4'h0;
   endsequence
   sequence poll_read_s;
      !flash_oe_n && !flash_ce_n && !flash_dq_oe;
   endsequence
   lock_confirm_a: assert property (
      state == S_WSET && op == OP_LOCK && step == 3'h3 |-> flash_dq_out == 16'h002f && flash_addr == usr_addr)
      else $error("lock confirm write wrong");
   unlock_first_a: assert property (
      state == S_WSET && step == 3'h0 && (op == OP_LOCK || op == OP_SERASE || op == OP_BERASE)
      |-> flash_addr == ADDR_W'(11'h555) && flash_dq_out == 16'h00aa)
      else $error("first unlock cycle wrong");
   sector_erase_a: assert property (
      state == S_WSET && op == OP_SERASE && step == 3'h5 |-> flash_dq_out == 16'h0030 && flash_addr == usr_addr)
      else $error("sector erase confirm wrong");
   bank_erase_a: assert property (
      state == S_WSET && op == OP_BERASE && step == 3'h5 |-> flash_dq_out == 16'h0010 && $past(step) == 3'h4)
      else $error("bank erase confirm wrong");
   pause_poll_a: assert property (
      pause_done_s |=> poll_read_s [*3] ##1 flash_oe_n)
      else $error("pause not followed by poll read");
   continue_a: assert property (
      state == S_WSET && op == OP_CONT |-> flash_dq_out == 16'h0030 && flash_addr == usr_addr)
      else $error("continue write wrong");
   pair_addr_a: assert property (
      state == S_WSET && op == OP_DWPROG && step == 3'h4
      |-> flash_addr[0] && flash_addr[ADDR_W-1:1] == usr_addr[ADDR_W-1:1] && $past(flash_addr[0], 4) == 1'b0)
      else $error("double word addresses not paired");
   read_reset_a: assert property (
      state == S_WSET && op == OP_RESET |-> flash_dq_out == 16'h00f0)
      else $error("read array command wrong");
   we_width_a: assert property (
      $fell(flash_we_n) |-> (!flash_we_n && !flash_ce_n && flash_dq_oe) [*2] ##1 flash_we_n)
      else $error("write pulse width wrong");
   ack_once_a: assert property (
      wb_req |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus answer wrong");
endmodule : fqc_host
`default_nettype wire

// [rtl/fqc_pkg.sv]
`default_nettype none
package fqc_pkg;
   // register map of the controller, byte addresses on the bus
   localparam logic [7:0] REG_CTRL  = 8'h00;
   localparam logic [7:0] REG_ADDR  = 8'h04;
   localparam logic [7:0] REG_WDATA = 8'h08;
   localparam logic [7:0] REG_STAT  = 8'h0c;
   localparam logic [7:0] REG_RDATA = 8'h10;
   localparam int STAT_BUSY    = 0;
   localparam int STAT_REFUSED = 1;
   localparam int STAT_STOPPED = 2;
   localparam int POLL_BIT     = 6;

   // coded cycle addresses, low bits only
   localparam logic [10:0] UNLOCK_A1  = 11'h555;
   localparam logic [10:0] UNLOCK_A2  = 11'h2aa;
   localparam logic [10:0] QUERY_ADDR = 11'h055;

   localparam logic [7:0] CMD_UNLOCK1  = 8'haa;
   localparam logic [7:0] CMD_UNLOCK2  = 8'h55;
   localparam logic [7:0] CMD_LOCK_SET = 8'h60;
   localparam logic [7:0] CMD_LOCK_CNF = 8'h2f;
   localparam logic [7:0] CMD_ERASE_SET = 8'h80;
   localparam logic [7:0] CMD_SECT_ERASE = 8'h30;
   localparam logic [7:0] CMD_BANK_ERASE = 8'h10;
   localparam logic [7:0] CMD_PAUSE    = 8'hb0;
   localparam logic [7:0] CMD_CONTINUE = 8'h30;
   localparam logic [7:0] CMD_READ_ARR = 8'hf0;
   localparam logic [7:0] CMD_QUERY    = 8'h98;
   localparam logic [7:0] CMD_ID_SEL   = 8'h90;
   localparam logic [7:0] CMD_DWPROG   = 8'h40;

   // query table of the device, word offsets and expected words
   localparam logic [7:0] QRY_MAKER_ID = 8'h00;
   localparam logic [7:0] QRY_PART_ID  = 8'h01;
   localparam logic [7:0] QRY_STR_Q    = 8'h10;
   localparam logic [7:0] QRY_STR_R    = 8'h11;
   localparam logic [7:0] QRY_STR_Y    = 8'h12;
   localparam logic [7:0] QRY_PRI_LO   = 8'h13;
   localparam logic [7:0] QRY_PRI_HI   = 8'h14;
   localparam logic [7:0] QRY_PTAB_LO  = 8'h15;
   localparam logic [7:0] QRY_PTAB_HI  = 8'h16;
   localparam logic [7:0] QRY_ALT_LO   = 8'h17;
   localparam logic [7:0] QRY_ALT_HI   = 8'h18;
   localparam logic [7:0] QRY_ATAB_LO  = 8'h19;
   localparam logic [7:0] QRY_ATAB_HI  = 8'h1a;
   localparam logic [15:0] QRY_VAL_Q = 16'h0051;
   localparam logic [15:0] QRY_VAL_R = 16'h0052;
   localparam logic [15:0] QRY_VAL_Y = 16'h0059;
   localparam logic [15:0] QRY_VAL_PRI_LO = 16'h0002;
   localparam logic [15:0] QRY_VAL_PTAB_LO = 16'h0040;
   localparam logic [15:0] QRY_VAL_ZERO = 16'h0000;

   // timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int T_WP_NS  = 200;
   localparam int T_WPH_NS = 100;
   localparam int T_ACC_NS = 100;
   localparam int SYNC_CYC = 2;
   localparam logic [3:0] WP_CYC   = 4'((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] WPH_CYC  = 4'((T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] READ_CYC = 4'((T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_CYC);

   typedef enum logic [3:0] {
      OP_READ    = 4'h0, OP_RESET   = 4'h1, OP_LOCK   = 4'h2, OP_SERASE = 4'h3,
      OP_SADD    = 4'h4, OP_BERASE  = 4'h5, OP_PAUSE  = 4'h6, OP_CONT   = 4'h7,
      OP_QUERY   = 4'h8, OP_IDSEL   = 4'h9, OP_DWPROG = 4'ha
   } fqc_op_e;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000, S_WSET = 3'b001, S_WPUL = 3'b010,
      S_WREC = 3'b011, S_READ = 3'b100, S_GAP  = 3'b101
   } fqc_state_e;

   // step word: {last, address select, data select, code}
   localparam logic [2:0] AS_555 = 3'h0;
   localparam logic [2:0] AS_2AA = 3'h1;
   localparam logic [2:0] AS_USR = 3'h2;
   localparam logic [2:0] AS_EVN = 3'h3;
   localparam logic [2:0] AS_ODD = 3'h4;
   localparam logic [2:0] AS_Q55 = 3'h5;
   localparam logic [1:0] DS_CODE = 2'h0;
   localparam logic [1:0] DS_LO   = 2'h1;
   localparam logic [1:0] DS_HI   = 2'h2;
endpackage : fqc_pkg
`default_nettype wire

// [tb/fqc_flash_model.sv]
`timescale 1ns/10ps
`default_nettype none
module fqc_flash_model #(
   parameter int          ADDR_W = 21,
   parameter logic [15:0] MAKER  = 16'h00c1, // arbitrary value
   parameter logic [15:0] PART   = 16'h00d2  // arbitrary value
) (
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [15:0]       dq_in,
   output var  logic [15:0]       dq_out,
   input  wire logic              ce_n,
   input  wire logic              we_n,
   input  wire logic              oe_n,
   output var  logic [7:0]        last_cmd,
   output var  logic [ADDR_W-1:0] last_addr,
   output var  logic              erasing,
   output var  logic              paused,
   output var  logic              dw_ok,
   output var  logic [31:0]       dw_word
);
   int                n    = 0;
   int                lag  = 0;
   logic [7:0]        code = 8'h00;
   logic              qmode = 1'b0;
   logic              tgl  = 1'b0;
   logic [ADDR_W-1:0] a1   = '0;
   logic [15:0]       last = 16'h0000;
   logic [15:0]       w1   = 16'h0000;
   logic [15:0]       rd;
   initial begin
      last_cmd = 8'h00;
      last_addr = '0;
      erasing = 1'b0;
      paused = 1'b0;
      dw_ok = 1'b0;
      dw_word = 32'h0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // query table
   function automatic logic [15:0] query_string_q(input logic [7:0] o);
      case (o)
         8'h00: return MAKER;
         8'h01: return PART;
         8'h10: return 16'h0051;
         8'h11: return 16'h0052;
         8'h12: return 16'h0059;
         8'h13: return 16'h0002;
         8'h15: return 16'h0040;
         default: return 16'h0000;
      endcase
   endfunction : query_string_q
   ////////////////////////////////////////////////////////////////////////////
   // only low address bits decoded
   always @(posedge we_n) if (!ce_n) begin : wr
      logic [10:0] a;
      logic [7:0]  d;
      logic        ok;
      a = addr[10:0];
      d = dq_in[7:0];
      if (d == 8'hf0) begin
         n = 0;
         qmode = 1'b0;
         last_cmd = d;
      end else if (n == 0 && d == 8'h98 && a == 11'h055) begin
         qmode = 1'b1;
      end else if (n == 0 && d == 8'hb0 && erasing && !paused) begin
         paused = 1'b1;
         lag = 2;
         last_cmd = d;
      end else if (n == 0 && d == 8'h30 && erasing) begin
         paused = 1'b0;
         last_cmd = d;
         last_addr = addr;
      end else begin
         if (code == 8'h40 && n >= 3) ok = 1'b1;
         else case (n)
            0: ok = d == 8'haa && a == 11'h555;
            1, 4: ok = d == 8'h55 && a == 11'h2aa;
            2: begin
               ok = a == 11'h555 && (d == 8'h60 || d == 8'h80 || d == 8'h90 || d == 8'h40);
               code = d;
            end
            3: ok = code == 8'h80 ? d == 8'haa && a == 11'h555 : d == 8'h2f;
            default: ok = d == 8'h30 || d == 8'h10;
         endcase
         n++;
         if (!ok) begin
            n = 0;
            qmode = 1'b0;
            last_cmd = 8'hff;
         end else if ((n == 3 && code == 8'h90) || (n == 4 && code == 8'h60) || n == 6 || (n == 5 && code == 8'h40)) begin
            dw_ok = (addr ^ a1) == 1;
            if (n == 5) dw_word = {dq_in, w1};
            last_cmd = n == 4 ? d : n == 3 || n == 5 ? code : d;
            last_addr = addr;
            erasing = erasing | n == 6;
            paused = paused & n != 6;
            n = 0;
         end else if (n == 4) begin
            a1 = addr;
            w1 = dq_in;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // toggle keeps running a few reads after a pause: the host must poll
   always @(negedge oe_n) if (!ce_n && erasing && (!paused || lag > 0)) begin
      tgl <= !tgl;
      if (paused) lag <= lag - 1;
   end
   // toggle status while an erase runs, else array or query data while selected
   assign rd = (erasing && (!paused || lag > 0)) ? {9'h000, tgl, 6'h00} :
               qmode ? query_string_q(addr[7:0]) : addr[15:0] ^ 16'h3c3c;
   // released bus shows the inverse of the last word
   always @(ce_n, oe_n, rd) begin
      if (!ce_n && !oe_n) begin
         dq_out = rd;
         last = rd;
      end else dq_out = ~last;
   end
endmodule : fqc_flash_model
`default_nettype wire

// [tb/fqc_host_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module fqc_host_tb;
   import fqc_pkg::*;
   localparam logic [15:0] QMAKER = 16'h00c1; // arbitrary value
   localparam logic [15:0] QPART  = 16'h00d2; // arbitrary value
   logic        clk = 0;
   logic        reset_n = 0;
   logic        cyc = 0;
   logic        stb = 0;
   logic        we = 0;
   logic [7:0]  adr = '0;
   logic [3:0]  sel = '0;
   logic [31:0] dat = '0;
   logic [31:0] dat_o, q, dww;
   logic        ack, dq_oe, ce_n, we_n, oe_n, ers, psd, dwok;
   logic [20:0] faddr, l_addr;
   logic [15:0] dq_o, dq_m, dq_w, w;
   logic [7:0]  l_cmd;
   int          err_count = 0;
   int          n_checks = 0;
   always #50 clk = ~clk;
   assign dq_w = dq_oe ? dq_o : dq_m;
   fqc_host i_fqc_host (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .flash_addr(faddr),
      .flash_dq_in(dq_w), .flash_dq_out(dq_o), .flash_dq_oe(dq_oe), .flash_ce_n(ce_n), .flash_we_n(we_n),
      .flash_oe_n(oe_n));
   fqc_flash_model #(.MAKER(QMAKER), .PART(QPART)) i_fqc_flash_model (.addr(faddr), .dq_in(dq_w),
      .dq_out(dq_m), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .last_cmd(l_cmd), .last_addr(l_addr),
      .erasing(ers), .paused(psd), .dw_ok(dwok), .dw_word(dww));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic wb(input logic w_, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clk);
      {cyc, stb, we, adr, dat, sel} <= {2'b11, w_, a, d, 4'hf};
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 100);
      r = dat_o;
      {cyc, stb, we} <= 3'b000;
      if (n >= 100) err_count++;
   endtask : wb
   task automatic run_op(input logic [3:0] op, input logic [20:0] a, input logic [31:0] d);
      int n;
      wb(1, REG_ADDR, {11'h000, a}, q);
      wb(1, REG_WDATA, d, q);
      wb(1, REG_CTRL, {28'h0, op}, q);
      n = 0;
      do begin
         wb(0, REG_STAT, 0, q);
         n++;
      end while (q[STAT_BUSY] !== 1'b0 && n < 300);
      if (n >= 300) err_count++;
   endtask : run_op
   task automatic rd_word(input logic [20:0] a);
      run_op(4'h0, a, 0);
      wb(0, REG_RDATA, 0, q);
      w = q[15:0];
   endtask : rd_word
   function automatic logic [15:0] qexp(input int o);
      case (o)
         0: return QMAKER;
         1: return QPART;
         'h10: return 16'h0051;
         'h11: return 16'h0052;
         'h12: return 16'h0059;
         'h13: return 16'h0002;
         'h15: return 16'h0040;
         default: return 16'h0000;
      endcase
   endfunction : qexp
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_idle;
      wb(0, REG_STAT, 0, q);
      chk(q, 0);
      wb(1, 8'h24, 32'hffffffff, q);
      wb(0, 8'h24, 0, q);
      chk(q, 0);
   endtask : t_idle
   task automatic t_lock;
      run_op(4'h2, 21'h1f5a5a, 0);
      chk(l_cmd, 8'h2f);
      chk(l_addr, 21'h1f5a5a);
   endtask : t_lock
   task automatic t_query;
      run_op(4'h8, 0, 0);
      for (int i = 0; i < 'h1b; i++) begin
         rd_word(i[20:0]);
         chk(w, qexp(i));
      end
      rd_word(21'h10);
      chk(w, 16'h0051);
      run_op(4'h1, 0, 0);
      chk(l_cmd, 8'hf0);
      rd_word(21'h0123);
      chk(w, 16'h0123 ^ 16'h3c3c);
   endtask : t_query
   task automatic t_erase;
      run_op(4'h3, 21'h0a0000, 0);
      chk({l_cmd, ers}, {8'h30, 1'b1});
      run_op(4'h4, 21'h0b0000, 0);
      chk(l_addr, 21'h0b0000);
      repeat (2) begin
         run_op(4'h6, 21'h0a0000, 0);
         wb(0, REG_STAT, 0, q);
         chk({q[STAT_STOPPED], psd}, 2'b11);
         rd_word(21'h1234);
         chk(w, 16'h1234 ^ 16'h3c3c);
         run_op(4'h7, 21'h0a0000, 0);
         chk({l_cmd, psd}, {8'h30, 1'b0});
      end
      run_op(4'h5, 21'h100000, 0);
      chk({l_cmd, l_addr}, {8'h10, 21'h100000});
   endtask : t_erase
   task automatic t_misc;
      wb(1, REG_CTRL, 32'h1, q);
      wb(1, REG_CTRL, 32'h1, q);
      run_op(4'hf, 0, 0);
      chk(q[STAT_REFUSED], 1'b1);
      chk(l_cmd, 8'hf0);
      wb(1, REG_STAT, 32'h2, q);
      wb(0, REG_STAT, 0, q);
      chk(q, 0);
      run_op(4'ha, 21'h000100, 32'hbeef1234);
      chk({l_cmd, dwok}, {8'h40, 1'b1});
      chk(dww, 32'hbeef1234);
      run_op(4'h9, 0, 0);
      chk(l_cmd, 8'h90);
   endtask : t_misc
   task automatic test_done;
      if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge clk);
      reset_n <= 1;
      t_idle();
      t_lock();
      t_query();
      t_erase();
      t_misc();
      test_done();
   end
   // whole run is about a thousand cycles
   initial begin
      #(100 * 60000);
      err_count++;
      test_done();
   end
endmodule : fqc_host_tb
`default_nettype wire
